// *** pin_function_pkg.sv ***
// constants, field layouts and carriers of the shared pin function select block
// assumes a paged 32-entry management register space with the page held at entry 31
package pin_function_pkg;

    localparam int          GPIO_COUNT      = 14;
    localparam int          LED_COUNT       = 4;
    localparam int          PHY_COUNT       = 4;

    // management addresses and page values
    localparam logic [4:0]  ADDR_PAGE       = 5'h1F;
    localparam logic [4:0]  ADDR_SELECT_A   = 5'h0D;
    localparam logic [4:0]  ADDR_SELECT_B   = 5'h0E;
    localparam logic [4:0]  ADDR_INPUTS     = 5'h0F;
    localparam logic [4:0]  ADDR_RSVD_HIGH  = 5'h1E;
    localparam logic [15:0] PAGE_GENERAL    = 16'h0010;
    localparam logic [15:0] PAGE_MAIN       = 16'h0000;

    // reset values and the stored-bit mask of select b
    localparam logic [15:0] RESET_SELECT_A  = 16'h0000;
    localparam logic [15:0] RESET_SELECT_B  = 16'h2600;
    localparam logic [15:0] SELECT_B_STORED = 16'hF7FF;

    // field positions in select a
    localparam int          SCL_FIELD_LSB   = 8;
    localparam int          DETECT_FIELD_LSB = 0;

    // field positions in select b
    localparam int          HIGH_PAIR_LSB   = 14;
    localparam int          LPH_DIR_N_BIT   = 13;
    localparam int          LPH_DATA_BIT    = 12;
    localparam int          LPH_LEVEL_BIT   = 11;
    localparam int          TWI_TRI_BIT     = 10;
    localparam int          LED_TRI_BIT     = 9;
    localparam int          TPULSE_EN_BIT   = 8;
    localparam int          GPIO11_LSB      = 6;
    localparam int          GPIO10_LSB      = 4;
    localparam int          FLF_LSB         = 2;
    localparam int          SDA_LSB         = 0;

    // pin indices with a dedicated role
    localparam int          PIN_SCL_FIRST   = 4;
    localparam int          PIN_SDA         = 8;
    localparam int          PIN_FLF         = 9;

    // field codes
    localparam logic [1:0]  MODE_DEDICATED  = 2'h0;
    localparam logic [1:0]  MODE_GPIO       = 2'h3;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_type;

    typedef struct packed {
        logic [15:0]           page;
        logic [15:0]           select_a;
        logic [15:0]           select_b;
        logic [15:0]           rdata;
        logic                  rvalid;
        logic [GPIO_COUNT-1:0] pin_out;
        logic [GPIO_COUNT-1:0] pin_oe;
        logic                  lph_out;
        logic                  lph_oe;
        logic [LED_COUNT-1:0]  led_out;
        logic [LED_COUNT-1:0]  led_oe;
        logic [PHY_COUNT-1:0]  detect;
        logic                  sda_in;
        logic                  tpulse_en;
    } core_state_type;

endpackage : pin_function_pkg

// *** pin_sync.sv ***
// two-stage synchroniser for a bank of pin levels
// assumes the inputs are asynchronous to clk_i
module pin_sync #(
    parameter int WIDTH = 15
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sync_state_type;

    sync_state_type cur;
    sync_state_type next_cur;

    // meta is read only by held, never by logic
    always_comb begin
        next_cur      = cur;
        next_cur.meta = d_i;
        next_cur.held = cur.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign q_o = cur.held;

endmodule : pin_sync

// *** shared_pin_function_select.sv ***
// global pin function select for the four-port phy: shared pin muxing and pin level readback
// assumes register 16 and 17 of the general page (output data, output enable) live elsewhere
// and arrive on gpio_drive_i / gpio_enable_i on the same clock; pins arrive asynchronously
module shared_pin_function_select (
    input  wire logic                                       clk_i,
    input  wire logic                                       rst_i,
    input  wire pin_function_pkg::mgmt_req_type             mgmt_req_i,
    output logic      [15:0]                                mgmt_rdata_o,
    output logic                                            mgmt_rvalid_o,
    input  wire logic [pin_function_pkg::GPIO_COUNT-1:0]    gpio_pin_i,
    output logic      [pin_function_pkg::GPIO_COUNT-1:0]    gpio_pin_o,
    output logic      [pin_function_pkg::GPIO_COUNT-1:0]    gpio_pin_oe_o,
    input  wire logic [pin_function_pkg::GPIO_COUNT-1:0]    gpio_drive_i,
    input  wire logic [pin_function_pkg::GPIO_COUNT-1:0]    gpio_enable_i,
    input  wire logic                                       lph_pin_i,
    output logic                                            lph_pin_o,
    output logic                                            lph_pin_oe_o,
    input  wire logic [pin_function_pkg::PHY_COUNT-1:0]     scl_level_i,
    input  wire logic                                       sda_out_i,
    input  wire logic                                       sda_oe_i,
    output logic                                            sda_in_o,
    input  wire logic                                       flf_level_i,
    output logic      [pin_function_pkg::PHY_COUNT-1:0]     fiber_signal_detect_o,
    input  wire logic [pin_function_pkg::LED_COUNT-1:0]     led_level_i,
    output logic      [pin_function_pkg::LED_COUNT-1:0]     led_pin_o,
    output logic      [pin_function_pkg::LED_COUNT-1:0]     led_pin_oe_o,
    output logic                                            time_pulse_enable_o
);

    localparam int GPIO_W = pin_function_pkg::GPIO_COUNT;

    localparam pin_function_pkg::core_state_type RESET_STATE = '{
        page:      pin_function_pkg::PAGE_MAIN,
        select_a:  pin_function_pkg::RESET_SELECT_A,
        select_b:  pin_function_pkg::RESET_SELECT_B,
        rdata:     16'h0000,
        rvalid:    1'b0,
        pin_out:   '0,
        pin_oe:    '0,
        lph_out:   1'b0,
        lph_oe:    1'b0,
        led_out:   '0,
        led_oe:    '0,
        detect:    '0,
        sda_in:    1'b1,
        tpulse_en: 1'b0
    };

    // one copy of the whole state, shared by all ports
    pin_function_pkg::core_state_type cur;
    pin_function_pkg::core_state_type next_cur;

    logic [GPIO_W:0]   synced;
    logic [GPIO_W-1:0] pin_level;
    logic              lph_level;

    // two-wire open-drain style: a high level is released when tri-state is set
    function automatic logic release_oe(input logic tri_bit, input logic level);
        release_oe = !tri_bit || !level;
    endfunction : release_oe

    // selection code of a shared pin from the two select registers
    function automatic logic [1:0] pin_code(input int idx, input logic [15:0] a, input logic [15:0] b);
        logic [1:0] code;
        code = pin_function_pkg::MODE_DEDICATED;
        if (idx < pin_function_pkg::PIN_SCL_FIRST) begin
            code = a[pin_function_pkg::DETECT_FIELD_LSB + 2 * idx +: 2];
        end else if (idx < pin_function_pkg::PIN_SDA) begin
            code = a[pin_function_pkg::SCL_FIELD_LSB + 2 * (idx - pin_function_pkg::PIN_SCL_FIRST) +: 2];
        end else if (idx == pin_function_pkg::PIN_SDA) begin
            code = b[pin_function_pkg::SDA_LSB +: 2];
        end else if (idx == pin_function_pkg::PIN_FLF) begin
            code = b[pin_function_pkg::FLF_LSB +: 2];
        end else if (idx == 10) begin
            code = b[pin_function_pkg::GPIO10_LSB +: 2];
        end else if (idx == 11) begin
            code = b[pin_function_pkg::GPIO11_LSB +: 2];
        end else begin
            code = b[pin_function_pkg::HIGH_PAIR_LSB +: 2];
        end
        pin_code = code;
    endfunction : pin_code

    // every pin level, low-power-hold included, is synchronised before use
    pin_sync #(
        .WIDTH (GPIO_W + 1)
    ) u_pin_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({lph_pin_i, gpio_pin_i}),
        .q_o   (synced)
    );

    assign pin_level = synced[GPIO_W-1:0];
    assign lph_level = synced[GPIO_W];

    // register port, pin routing and readback
    always_comb begin
        logic [1:0] code;
        logic       on_general;
        logic       twi_tri;
        logic       led_tri;
        code       = pin_function_pkg::MODE_DEDICATED;
        next_cur   = cur;
        on_general = (cur.page == pin_function_pkg::PAGE_GENERAL);
        twi_tri    = cur.select_b[pin_function_pkg::TWI_TRI_BIT];
        led_tri    = cur.select_b[pin_function_pkg::LED_TRI_BIT];

        // read answers the value from before a same-cycle write
        next_cur.rvalid = 1'b0;
        next_cur.rdata  = 16'h0000;
        if (mgmt_req_i.rd) begin
            if (mgmt_req_i.addr == pin_function_pkg::ADDR_PAGE) begin
                next_cur.rvalid = 1'b1;
                next_cur.rdata  = cur.page;
            end else if (on_general) begin
                // the reserved entries answer zero so software polling them sees no fault
                if (mgmt_req_i.addr <= pin_function_pkg::ADDR_INPUTS ||
                    mgmt_req_i.addr == pin_function_pkg::ADDR_RSVD_HIGH) begin
                    next_cur.rvalid = 1'b1;
                end
                case (mgmt_req_i.addr)
                    pin_function_pkg::ADDR_SELECT_A: begin
                        next_cur.rdata = cur.select_a;
                    end
                    pin_function_pkg::ADDR_SELECT_B: begin
                        next_cur.rdata = cur.select_b;
                        next_cur.rdata[pin_function_pkg::LPH_LEVEL_BIT] = lph_level;
                    end
                    pin_function_pkg::ADDR_INPUTS: begin
                        next_cur.rdata = {2'h0, pin_level};
                    end
                    default: begin
                        next_cur.rdata = 16'h0000;
                    end
                endcase
            end
        end

        // writes; the level bit of select b is never stored
        if (mgmt_req_i.wr) begin
            if (mgmt_req_i.addr == pin_function_pkg::ADDR_PAGE) begin
                next_cur.page = mgmt_req_i.wdata;
            end else if (on_general && mgmt_req_i.addr == pin_function_pkg::ADDR_SELECT_A) begin
                next_cur.select_a = mgmt_req_i.wdata;
            end else if (on_general && mgmt_req_i.addr == pin_function_pkg::ADDR_SELECT_B) begin
                next_cur.select_b = mgmt_req_i.wdata & pin_function_pkg::SELECT_B_STORED;
            end
        end

        // shared pins; reserved codes leave the pin floating and unused
        next_cur.detect = '0;
        next_cur.sda_in = 1'b1;
        for (int i = 0; i < GPIO_W; i++) begin
            code                = pin_code(i, cur.select_a, cur.select_b);
            next_cur.pin_out[i] = 1'b0;
            next_cur.pin_oe[i]  = 1'b0;
            if (code == pin_function_pkg::MODE_GPIO) begin
                // gpio: driven when enabled, else floating while still sampled above
                next_cur.pin_out[i] = gpio_drive_i[i];
                next_cur.pin_oe[i]  = gpio_enable_i[i];
            end else if (code == pin_function_pkg::MODE_DEDICATED) begin
                if (i < pin_function_pkg::PIN_SCL_FIRST) begin
                    next_cur.detect[i] = pin_level[i];
                end else if (i < pin_function_pkg::PIN_SDA) begin
                    next_cur.pin_out[i] = scl_level_i[i - pin_function_pkg::PIN_SCL_FIRST];
                    next_cur.pin_oe[i]  = release_oe(twi_tri,
                                          scl_level_i[i - pin_function_pkg::PIN_SCL_FIRST]);
                end else if (i == pin_function_pkg::PIN_SDA) begin
                    next_cur.pin_out[i] = sda_out_i;
                    next_cur.pin_oe[i]  = sda_oe_i && release_oe(twi_tri, sda_out_i);
                    next_cur.sda_in     = pin_level[i];
                end else if (i == pin_function_pkg::PIN_FLF) begin
                    next_cur.pin_out[i] = flf_level_i;
                    next_cur.pin_oe[i]  = 1'b1;
                end
            end
        end

        // led pins: a high level floats when tri-state is set, for pull-ups above the rail
        for (int j = 0; j < pin_function_pkg::LED_COUNT; j++) begin
            next_cur.led_out[j] = led_level_i[j];
            next_cur.led_oe[j]  = release_oe(led_tri, led_level_i[j]);
        end

        // low-power-hold pin, direction bit is active low
        next_cur.lph_oe  = !cur.select_b[pin_function_pkg::LPH_DIR_N_BIT];
        next_cur.lph_out = cur.select_b[pin_function_pkg::LPH_DATA_BIT];

        // software keeps this clear while the daisy-chain input shares the pin
        next_cur.tpulse_en = cur.select_b[pin_function_pkg::TPULSE_EN_BIT];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state flops
    assign mgmt_rdata_o        = cur.rdata;
    assign mgmt_rvalid_o       = cur.rvalid;
    assign gpio_pin_o          = cur.pin_out;
    assign gpio_pin_oe_o       = cur.pin_oe;
    assign lph_pin_o           = cur.lph_out;
    assign lph_pin_oe_o        = cur.lph_oe;
    assign sda_in_o            = cur.sda_in;
    assign fiber_signal_detect_o = cur.detect;
    assign led_pin_o           = cur.led_out;
    assign led_pin_oe_o        = cur.led_oe;
    assign time_pulse_enable_o = cur.tpulse_en;

endmodule : shared_pin_function_select

// *** pin_select_chk.sv ***
// port-level assertions for the shared pin function select block
// assumes one clock with synchronous active-high reset; bound to the top module
module pin_select_chk (
    input wire logic                           clk_i,
    input wire logic                           rst_i,
    input wire pin_function_pkg::mgmt_req_type mgmt_req_i,
    input wire logic [15:0]                    mgmt_rdata_o,
    input wire logic                           mgmt_rvalid_o,
    input wire logic [13:0]                    gpio_pin_o,
    input wire logic [13:0]                    gpio_pin_oe_o,
    input wire logic [13:0]                    gpio_drive_i,
    input wire logic [13:0]                    gpio_enable_i,
    input wire logic                           lph_pin_o,
    input wire logic                           lph_pin_oe_o,
    input wire logic [3:0]                     scl_level_i,
    input wire logic                           sda_out_i,
    input wire logic                           sda_oe_i,
    input wire logic [3:0]                     led_level_i,
    input wire logic [3:0]                     led_pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] GEN = pin_function_pkg::PAGE_GENERAL;
    logic [15:0] page, sel_a, sel_b;
    logic [13:0] gm;
    logic        up;
    // shadows of page and select registers; up skips the edge right after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page <= 16'h0000;
            sel_a <= pin_function_pkg::RESET_SELECT_A;
            sel_b <= pin_function_pkg::RESET_SELECT_B;
            up <= 1'h0;
        end else begin
            up <= 1'h1;
            if (mgmt_req_i.wr && mgmt_req_i.addr == 5'h1F) page <= mgmt_req_i.wdata;
            if (mgmt_req_i.wr && page == GEN && mgmt_req_i.addr == 5'h0D) sel_a <= mgmt_req_i.wdata;
            if (mgmt_req_i.wr && page == GEN && mgmt_req_i.addr == 5'h0E) sel_b <= mgmt_req_i.wdata;
        end
    end
    // pins handed to the general-purpose registers
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            gm[n] = sel_a[2*n +: 2] == 2'h3;
            gm[n+4] = sel_a[2*n+8 +: 2] == 2'h3;
            gm[n+8] = sel_b[2*n +: 2] == 2'h3;
        end
        gm[13:12] = {2{sel_b[15:14] == 2'h3}};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !up);
    a_page_refuse: assert property (
        mgmt_req_i.rd && page != GEN && mgmt_req_i.addr != 5'h1F |=> !mgmt_rvalid_o) else $error("answer off page");
    a_input_top: assert property (
        mgmt_rvalid_o && $past(mgmt_req_i.addr) == 5'h0F && $past(page) == GEN |-> mgmt_rdata_o[15:14] == 2'h0)
        else $error("input top bits set");
    a_gpio_drive: assert property (
        ($past(gm) & ((gpio_pin_oe_o ^ $past(gpio_enable_i)) | (gpio_pin_oe_o & (gpio_pin_o ^ $past(gpio_drive_i)))))
        == 14'h0000) else $error("gpio pin not from its registers");
    a_top_float: assert property ((~$past(gm[13:10]) & gpio_pin_oe_o[13:10]) == 4'h0)
        else $error("unassigned pin driven");
    a_lph_dir: assert property (lph_pin_oe_o == !$past(sel_b[13])) else $error("hold pin direction wrong");
    a_lph_data: assert property (lph_pin_oe_o |-> lph_pin_o == $past(sel_b[12])) else $error("hold pin data");
    a_led_tri: assert property (
        led_pin_oe_o == ($past(sel_b[9]) ? ~$past(led_level_i) : 4'hF)) else $error("led enable wrong");
    a_sda_tri: assert property ($past(sel_b[1:0]) == 2'h0 |->
        gpio_pin_oe_o[8] == ($past(sda_oe_i) && (!$past(sel_b[10]) || !$past(sda_out_i)))) else $error("data enable");
    a_scl_tri: assert property ($past(sel_a[9:8]) == 2'h0 |->
        gpio_pin_oe_o[4] == (!$past(sel_b[10]) || !$past(scl_level_i[0]))) else $error("clock pin enable");
endmodule : pin_select_chk

bind shared_pin_function_select pin_select_chk chk (
    .clk_i, .rst_i, .mgmt_req_i, .mgmt_rdata_o, .mgmt_rvalid_o, .gpio_pin_o, .gpio_pin_oe_o, .gpio_drive_i,
    .gpio_enable_i, .lph_pin_o, .lph_pin_oe_o, .scl_level_i, .sda_out_i, .sda_oe_i, .led_level_i, .led_pin_oe_o
);

// *** shared_pin_function_select_tb.sv ***
// self-checking bench for the shared pin function select block
// assumes the checker is bound separately; the bench drives every input itself
module shared_pin_function_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] SEL_A = pin_function_pkg::ADDR_SELECT_A;
    localparam logic [4:0] SEL_B = pin_function_pkg::ADDR_SELECT_B;
    logic                           clk_i = 1'h0, rst_i = 1'h1;
    pin_function_pkg::mgmt_req_type mgmt_req_i = '0;
    logic [15:0]                    mgmt_rdata_o;
    logic                           mgmt_rvalid_o, lph_pin_o, lph_pin_oe_o, sda_in_o, time_pulse_enable_o;
    logic                           lph_pin_i = 1'h0, sda_out_i = 1'h0, sda_oe_i = 1'h0, flf_level_i = 1'h0;
    logic [13:0]                    gpio_pin_o, gpio_pin_oe_o, pins;
    logic [13:0]                    gpio_pin_i = 14'h0000, gpio_drive_i = 14'h0000, gpio_enable_i = 14'h0000;
    logic [3:0]                     fiber_signal_detect_o, led_pin_o, led_pin_oe_o, lvl;
    logic [3:0]                     scl_level_i = 4'h0, led_level_i = 4'h0;
    logic [5:0]                     e_oe;
    logic [15:0]                    exp_q[$];
    int                             fails = 0, cmp_count = 0, cycles = 0;

    shared_pin_function_select uut (
        .clk_i, .rst_i, .mgmt_req_i, .mgmt_rdata_o, .mgmt_rvalid_o, .gpio_pin_i, .gpio_pin_o, .gpio_pin_oe_o,
        .gpio_drive_i, .gpio_enable_i, .lph_pin_i, .lph_pin_o, .lph_pin_oe_o, .scl_level_i, .sda_out_i,
        .sda_oe_i, .sda_in_o, .flf_level_i, .fiber_signal_detect_o, .led_level_i, .led_pin_o, .led_pin_oe_o,
        .time_pulse_enable_o
    );

    always #4 clk_i = ~clk_i;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : check
    // one strobe, dropped after its edge so a following request never shares a time step
    task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        mgmt_req_i <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge clk_i);
        mgmt_req_i <= '0;
    endtask : acc
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        acc(1'h0, a, 16'h0000);
    endtask : rd
    // covers synchroniser plus output register latency
    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // answers are matched in issue order; an answer nobody asked for is a mismatch
    // sampled mid-cycle, where the registered answer has settled
    always @(negedge clk_i) begin
        if (mgmt_rvalid_o === 1'h1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("unexpected at %0t: read answer with none pending", $time);
            end else begin
                check(mgmt_rdata_o, exp_q.pop_front());
            end
        end
    end
    // hang guard, well above the roughly 130 cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(79419));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        acc(1'h0, SEL_A, 16'h0000);
        rd(5'h1F, 16'h0000);
        acc(1'h1, 5'h1F, pin_function_pkg::PAGE_GENERAL);
        rd(SEL_A, 16'h0000);
        rd(SEL_B, 16'h2600);
        for (int a = 0; a < 31; a++) begin
            if (a < 13 || a == 30) begin
                acc(1'h1, 5'(a), 16'hFFFF);
                rd(5'(a), 16'h0000);
            end
        end
        pins = 14'($urandom);
        gpio_pin_i <= pins;
        lph_pin_i <= 1'h1;
        settle();
        rd(pin_function_pkg::ADDR_INPUTS, {2'h0, pins});
        rd(SEL_B, 16'h2E00);
        check({fiber_signal_detect_o, sda_in_o}, {pins[3:0], pins[8]});
        // every pin handed to the general-purpose registers, hold pin driven
        gpio_drive_i <= 14'($urandom);
        gpio_enable_i <= 14'($urandom);
        led_level_i <= 4'($urandom);
        acc(1'h1, SEL_A, 16'hFFFF);
        acc(1'h1, SEL_B, 16'hD1FF);
        settle();
        rd(SEL_B, 16'hD9FF);
        check(gpio_pin_oe_o, gpio_enable_i);
        check(gpio_pin_o & gpio_enable_i, gpio_drive_i & gpio_enable_i);
        check({fiber_signal_detect_o, lph_pin_oe_o, lph_pin_o, time_pulse_enable_o, sda_in_o}, 8'h0F);
        check({led_pin_oe_o, led_pin_o}, {4'hF, led_level_i});
        // reserved codes leave every shared pin floating
        acc(1'h1, SEL_A, 16'h5555);
        acc(1'h1, SEL_B, 16'h6AAA);
        settle();
        rd(SEL_B, 16'h6AAA);
        check(gpio_pin_oe_o, 14'h0000);
        check({lph_pin_oe_o, time_pulse_enable_o, led_pin_oe_o}, {2'h0, ~led_level_i});
        // dedicated two-wire and link-fail pins, alternating tri-state
        acc(1'h1, SEL_A, 16'h0000);
        for (int t = 0; t < 4; t++) begin
            // new levels go in on a rising edge, not after the settle delay
            @(posedge clk_i);
            lvl = 4'($urandom);
            scl_level_i <= lvl;
            sda_out_i <= lvl[1];
            flf_level_i <= lvl[0];
            sda_oe_i <= 1'h1;
            acc(1'h1, SEL_B, t[0] ? 16'h0400 : 16'h0000);
            settle();
            e_oe = {1'h1, !(t[0] && lvl[1]), t[0] ? ~lvl : 4'hF};
            check(gpio_pin_oe_o[9:4], e_oe);
            check(gpio_pin_o[9:4] & e_oe, {lvl[0], lvl[1], lvl} & e_oe);
        end
        settle();
        check(16'(exp_q.size()), 16'h0000);
        finish_test();
    end
endmodule : shared_pin_function_select_tb
